// ### inc/pepseq_pkg.sv
/*
 * Package for the print engine period sequencer: period codes,
 * cleaning intervals and counter widths.
 * Assumes a single 100 MHz clock domain and synchronous inputs.
 */
`default_nettype none

package pepseq_pkg;

    // ********************************************************
    // Periods, one-hot
    // ********************************************************
    typedef enum logic [5:0] {
        PEPSEQ_POWERUP_WAIT = 6'h01,
        PEPSEQ_IDLE_READY   = 6'h02,
        PEPSEQ_SLEEP        = 6'h04,
        PEPSEQ_INIT_ROT     = 6'h08,
        PEPSEQ_PRINT        = 6'h10,
        PEPSEQ_LAST_ROT     = 6'h20
    } pepseq_period_t;

    // Encoded period reported to the formatter
    localparam logic [2:0] PEPSEQ_CODE_WAIT     = 3'h0;
    localparam logic [2:0] PEPSEQ_CODE_IDLE     = 3'h1;
    localparam logic [2:0] PEPSEQ_CODE_SLEEP    = 3'h2;
    localparam logic [2:0] PEPSEQ_CODE_INIT_ROT = 3'h3;
    localparam logic [2:0] PEPSEQ_CODE_PRINT    = 3'h4;
    localparam logic [2:0] PEPSEQ_CODE_LAST_ROT = 3'h5;

    // ********************************************************
    // Cleaning intervals in pages
    // ********************************************************
    localparam int         PEPSEQ_CNT_W          = 7;
    localparam logic [6:0] PEPSEQ_CART_INTERVAL  = 7'h23;
    localparam logic [6:0] PEPSEQ_BELT_INTERVAL  = 7'h64;
    localparam logic [6:0] PEPSEQ_CNT_RESET      = 7'h00;

endpackage : pepseq_pkg

`default_nettype wire

// ### hdl/pepseq_page_divider.sv
/*
 * Page divider: counts page pulses and fires a one-cycle tick every
 * INTERVAL pages. Used once per cleaning kind.
 * Assumes pageDone is a one-cycle pulse in the same clock domain.
 */
`default_nettype none

module pepseq_page_divider
    import pepseq_pkg::*;
#(
    parameter logic [PEPSEQ_CNT_W-1:0] INTERVAL = PEPSEQ_CART_INTERVAL
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Page events
    input  wire logic pageDone,
    output logic      tick
);

    typedef struct packed {
        logic [PEPSEQ_CNT_W-1:0] count;
        logic                    tick;
    } pepseq_div_t;

    pepseq_div_t state;
    pepseq_div_t next_state;

    always_comb begin
        next_state      = state;
        next_state.tick = 1'b0;
        if (pageDone) begin
            if (state.count == INTERVAL - 7'h01) begin
                next_state.count = PEPSEQ_CNT_RESET;
                next_state.tick  = 1'b1;
            end else begin
                next_state.count = state.count + 7'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick = state.tick;

endmodule : pepseq_page_divider

`default_nettype wire

// ### hdl/pepseq_sequencer.sv
/*
 * Print engine period sequencer: power-up wait, idle ready, sleep,
 * initial rotation, print and last rotation, with page-count driven
 * cartridge and transfer belt cleaning requests and status to the
 * formatter.
 * Assumes all inputs are synchronous to clk; subsystem done and
 * sensor inputs are levels or pulses held at least one cycle.
 */
`default_nettype none

module pepseq_sequencer
    import pepseq_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Formatter commands and video
    input  wire logic       printCmd,
    input  wire logic       sleepCmd,
    input  wire logic       wakeCmd,
    input  wire logic       videoIn,
    // Subsystem completions and sensors
    input  wire logic       beltCleanDone,
    input  wire logic       cartCleanDone,
    input  wire logic       checksDone,
    input  wire logic       adjustNeeded,
    input  wire logic       adjustDone,
    input  wire logic       rotationReady,
    input  wire logic       leadingEdgeSensed,
    input  wire logic       transferBiasOff,
    input  wire logic       drumMotorStopped,
    input  wire logic       tonerLow,
    input  wire logic       cartridgeMissing,
    input  wire logic       subsysFault,
    // Engine actions
    output logic            beltCleanReq,
    output logic            cartCleanReq,
    output logic            checkReq,
    output logic            adjustReq,
    output logic            motorRunReq,
    output logic            laserOn,
    output logic            lowPowerMode,
    // Formatter status
    output logic            pageSync,
    output logic [2:0]      periodCode,
    output logic            readyToPrint,
    output logic            statusTonerLow,
    output logic            statusNoCartridge,
    output logic            statusFault
);

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        pepseq_period_t period;
        logic           sheetSeen;
        logic           checksOk;
        logic           adjustOk;
        logic           beltPend;
        logic           cartPend;
        logic           pageSync;
        logic           pageDone;
        logic           laserOn;
        logic [2:0]     code;
        logic           tonerLow;
        logic           noCart;
        logic           fault;
    } pepseq_state_t;

    pepseq_state_t state;
    pepseq_state_t next_state;
    logic          cartTick;
    logic          beltTick;

    // ********************************************************
    // Page dividers
    // ********************************************************
    pepseq_page_divider #(
        .INTERVAL (PEPSEQ_CART_INTERVAL)
    ) u_cart_div (
        .clk      (clk),
        .rst_b    (rst_b),
        .pageDone (state.pageDone),
        .tick     (cartTick)
    );

    pepseq_page_divider #(
        .INTERVAL (PEPSEQ_BELT_INTERVAL)
    ) u_belt_div (
        .clk      (clk),
        .rst_b    (rst_b),
        .pageDone (state.pageDone),
        .tick     (beltTick)
    );

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        next_state          = state;
        next_state.pageSync = 1'b0;
        next_state.pageDone = 1'b0;
        next_state.laserOn  = 1'b0;

        // Ticks win over completion so no cleaning is lost
        if (cartCleanDone) begin
            next_state.cartPend = 1'b0;
        end
        if (beltCleanDone) begin
            next_state.beltPend = 1'b0;
        end
        if (cartTick) begin
            next_state.cartPend = 1'b1;
        end
        if (beltTick) begin
            next_state.beltPend = 1'b1;
        end

        unique case (state.period)
            PEPSEQ_POWERUP_WAIT: begin
                if (checksDone) begin
                    next_state.checksOk = 1'b1;
                end
                if (!adjustNeeded || adjustDone) begin
                    next_state.adjustOk = 1'b1;
                end
                // Belt cleaning is last; checks must be done first
                if (beltCleanDone && state.checksOk && state.adjustOk) begin
                    next_state.period = PEPSEQ_IDLE_READY;
                end
            end
            PEPSEQ_IDLE_READY: begin
                if (printCmd) begin
                    next_state.period = PEPSEQ_INIT_ROT;
                end else if (sleepCmd) begin
                    next_state.period = PEPSEQ_SLEEP;
                end
            end
            PEPSEQ_SLEEP: begin
                // Waking lands in idle ready, not straight into print
                if (wakeCmd || printCmd) begin
                    next_state.period = PEPSEQ_IDLE_READY;
                end
            end
            PEPSEQ_INIT_ROT: begin
                if (rotationReady) begin
                    next_state.pageSync  = 1'b1;
                    next_state.sheetSeen = 1'b0;
                    next_state.period    = PEPSEQ_PRINT;
                end
            end
            PEPSEQ_PRINT: begin
                next_state.laserOn = videoIn;
                if (leadingEdgeSensed) begin
                    next_state.sheetSeen = 1'b1;
                end
                if (state.sheetSeen && transferBiasOff) begin
                    next_state.pageDone = 1'b1;
                    next_state.period   = PEPSEQ_LAST_ROT;
                end
            end
            PEPSEQ_LAST_ROT: begin
                if (printCmd) begin
                    next_state.period = PEPSEQ_INIT_ROT;
                end else if (drumMotorStopped) begin
                    next_state.period = PEPSEQ_IDLE_READY;
                end
            end
            default: begin
                next_state.period = PEPSEQ_POWERUP_WAIT;
            end
        endcase

        unique case (next_state.period)
            PEPSEQ_POWERUP_WAIT: next_state.code = PEPSEQ_CODE_WAIT;
            PEPSEQ_IDLE_READY:   next_state.code = PEPSEQ_CODE_IDLE;
            PEPSEQ_SLEEP:        next_state.code = PEPSEQ_CODE_SLEEP;
            PEPSEQ_INIT_ROT:     next_state.code = PEPSEQ_CODE_INIT_ROT;
            PEPSEQ_PRINT:        next_state.code = PEPSEQ_CODE_PRINT;
            PEPSEQ_LAST_ROT:     next_state.code = PEPSEQ_CODE_LAST_ROT;
            default:             next_state.code = PEPSEQ_CODE_WAIT;
        endcase

        next_state.tonerLow = tonerLow;
        next_state.noCart   = cartridgeMissing;
        next_state.fault    = subsysFault;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state          <= '0;
            state.period   <= PEPSEQ_POWERUP_WAIT;
            state.beltPend <= 1'b1;
            state.code     <= PEPSEQ_CODE_WAIT;
        end else begin
            state <= next_state;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    // Cleaning requests run only in wait or idle ready so a sheet
    // in flight is never disturbed
    assign beltCleanReq = state.beltPend &&
                          (state.period == PEPSEQ_POWERUP_WAIT ||
                           state.period == PEPSEQ_IDLE_READY);
    assign cartCleanReq = state.cartPend &&
                          state.period == PEPSEQ_IDLE_READY;
    assign checkReq     = state.period == PEPSEQ_POWERUP_WAIT &&
                          !state.checksOk;
    assign adjustReq    = state.period == PEPSEQ_POWERUP_WAIT &&
                          !state.adjustOk;
    assign motorRunReq  = state.period == PEPSEQ_INIT_ROT ||
                          state.period == PEPSEQ_PRINT ||
                          state.period == PEPSEQ_LAST_ROT;
    assign lowPowerMode = state.period == PEPSEQ_SLEEP;
    assign readyToPrint = state.period == PEPSEQ_IDLE_READY;

    assign laserOn           = state.laserOn;
    assign pageSync          = state.pageSync;
    assign periodCode        = state.code;
    assign statusTonerLow    = state.tonerLow;
    assign statusNoCartridge = state.noCart;
    assign statusFault       = state.fault;

endmodule : pepseq_sequencer

`default_nettype wire

// ### verif/pepseq_seq_monitor.sv
/*
 * Checker for the period sequencer, bound to its ports.
 * Assumes one clock domain and an active-low synchronous reset.
 */
`default_nettype none

module pepseq_seq_monitor
    import pepseq_pkg::*;
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_b,
    // Commands and sensors
    input wire logic       printCmd,
    input wire logic       sleepCmd,
    input wire logic       videoIn,
    input wire logic       rotationReady,
    input wire logic       leadingEdgeSensed,
    input wire logic       transferBiasOff,
    input wire logic       drumMotorStopped,
    // Status outputs
    input wire logic       pageSync,
    input wire logic       laserOn,
    input wire logic       lowPowerMode,
    input wire logic       readyToPrint,
    input wire logic [2:0] periodCode
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ****************************
    // Period transitions
    // ****************************
    sequence s_sheet;
        periodCode == PEPSEQ_CODE_PRINT && leadingEdgeSensed;
    endsequence
    sequence s_bias;
        periodCode == PEPSEQ_CODE_PRINT && transferBiasOff;
    endsequence
    property p_sync_pulse; pageSync |=> !pageSync; endproperty
    a_sync_pulse: assert property (p_sync_pulse)
        else $error("page sync wider than one cycle");
    property p_sync_entry; periodCode == PEPSEQ_CODE_INIT_ROT && rotationReady
        |=> pageSync && periodCode == PEPSEQ_CODE_PRINT; endproperty
    a_sync_entry: assert property (p_sync_entry)
        else $error("no page sync after rotation ready");
    property p_sleep; periodCode == PEPSEQ_CODE_IDLE && sleepCmd && !printCmd
        |=> lowPowerMode && periodCode == PEPSEQ_CODE_SLEEP; endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep command not taken");
    property p_sheet_done;
        s_sheet ##1 s_bias |=> periodCode == PEPSEQ_CODE_LAST_ROT;
    endproperty
    a_sheet_done: assert property (p_sheet_done)
        else $error("print period did not end");
    property p_print_hold; periodCode == PEPSEQ_CODE_PRINT && !transferBiasOff
        |=> periodCode == PEPSEQ_CODE_PRINT; endproperty
    a_print_hold: assert property (p_print_hold)
        else $error("print period left early");
    property p_restart; periodCode == PEPSEQ_CODE_LAST_ROT && printCmd
        |=> periodCode == PEPSEQ_CODE_INIT_ROT; endproperty
    a_restart: assert property (p_restart)
        else $error("print in last rotation not restarted");
    property p_last_end; periodCode == PEPSEQ_CODE_LAST_ROT
        && drumMotorStopped && !printCmd
        |=> readyToPrint && periodCode == PEPSEQ_CODE_IDLE; endproperty
    a_last_end: assert property (p_last_end)
        else $error("last rotation did not end in idle");
    // Only checked mid-print: entry cycle gating is the designer's choice
    property p_laser; periodCode == PEPSEQ_CODE_PRINT
        && $past(periodCode) == PEPSEQ_CODE_PRINT
        |-> laserOn == $past(videoIn); endproperty
    a_laser: assert property (p_laser)
        else $error("laser does not follow video");
    // Last print cycle may still carry video into the next period
    property p_laser_off; periodCode != PEPSEQ_CODE_PRINT
        && $past(periodCode) != PEPSEQ_CODE_PRINT
        |-> !laserOn; endproperty
    a_laser_off: assert property (p_laser_off)
        else $error("laser on outside print period");
endmodule : pepseq_seq_monitor

bind pepseq_sequencer pepseq_seq_monitor u_mon (
    .clk, .rst_b, .printCmd, .sleepCmd, .videoIn, .rotationReady,
    .leadingEdgeSensed, .transferBiasOff, .drumMotorStopped, .pageSync,
    .laserOn, .lowPowerMode, .readyToPrint, .periodCode
);

`default_nettype wire

// ### verif/pepseq_formatter_model.sv
/*
 * Formatter model: supplies the video stream to the engine.
 * Assumes the engine samples videoIn on the rising clk edge.
 */
`default_nettype none

module pepseq_formatter_model
    import pepseq_pkg::*;
(
    // Clock
    input  wire logic       clk,
    // Engine period
    input  wire logic [2:0] periodCode,
    // Video
    output logic            videoIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] phase = 3'h0;
    // Changes every cycle outside print and in six of every eight cycles in print, so a stale laser value seldom passes
    always @(negedge clk) begin
        phase <= phase + 3'h1;
        videoIn <= (periodCode == PEPSEQ_CODE_PRINT) ?
                   (phase[0] ^ phase[2]) : phase[0];
    end
endmodule : pepseq_formatter_model

`default_nettype wire

// ### verif/pepseq_tb.sv
/*
 * Self-checking bench for the period sequencer and formatter model.
 * Assumes the checker binds itself to the sequencer.
 */
`default_nettype none

module tb
    import pepseq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 1'b0;
    logic       rst_b, printCmd, sleepCmd, wakeCmd, videoIn;
    logic       beltCleanDone, cartCleanDone, checksDone, adjustNeeded;
    logic       adjustDone, rotationReady, leadingEdgeSensed;
    logic       transferBiasOff, drumMotorStopped, tonerLow;
    logic       cartridgeMissing, subsysFault, beltCleanReq, cartCleanReq;
    logic       checkReq, adjustReq, motorRunReq, laserOn, lowPowerMode;
    logic       pageSync, readyToPrint, statusTonerLow, statusNoCartridge;
    logic       statusFault;
    logic [2:0] periodCode;
    int         failures = 0;
    int         cmpCount = 0;

    pepseq_sequencer dut (
        .clk, .rst_b, .printCmd, .sleepCmd, .wakeCmd, .videoIn,
        .beltCleanDone, .cartCleanDone, .checksDone, .adjustNeeded,
        .adjustDone, .rotationReady, .leadingEdgeSensed, .transferBiasOff,
        .drumMotorStopped, .tonerLow, .cartridgeMissing, .subsysFault,
        .beltCleanReq, .cartCleanReq, .checkReq, .adjustReq, .motorRunReq,
        .laserOn, .lowPowerMode, .pageSync, .periodCode, .readyToPrint,
        .statusTonerLow, .statusNoCartridge, .statusFault
    );
    pepseq_formatter_model fmt (.clk, .periodCode, .videoIn);

    always #5 clk = ~clk;

    // ****************************
    // Shared tasks
    // ****************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmpCount++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // One-cycle command: sleep, print, wake
    // Only the raised bits are touched, so back-to-back calls with no
    // common bit never write one command line twice in the same time step
    task automatic cmd(input logic [2:0] spw);
        if (spw[2]) sleepCmd = 1'b1;
        if (spw[1]) printCmd = 1'b1;
        if (spw[0]) wakeCmd = 1'b1;
        cyc(1);
        if (spw[2]) sleepCmd = 1'b0;
        if (spw[1]) printCmd = 1'b0;
        if (spw[0]) wakeCmd = 1'b0;
    endtask : cmd
    task automatic print_verdict();
        $display("comparisons=%0d mismatches=%0d", cmpCount, failures);
        if (failures == 0 && cmpCount > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    // ****************************
    // Scenarios
    // ****************************
    task automatic do_page(input logic again);
        cmd(3'h2);
        chk({motorRunReq, periodCode}, {1'b1, PEPSEQ_CODE_INIT_ROT});
        cmd(3'h4);
        chk(periodCode, PEPSEQ_CODE_INIT_ROT);
        rotationReady = 1'b1;
        cyc(1);
        rotationReady = 1'b0;
        transferBiasOff = 1'b1;
        chk({pageSync, periodCode}, {1'b1, PEPSEQ_CODE_PRINT});
        cmd(3'h2);
        transferBiasOff = 1'b0;
        chk({pageSync, periodCode}, {1'b0, PEPSEQ_CODE_PRINT});
        leadingEdgeSensed = 1'b1;
        cyc(1);
        leadingEdgeSensed = 1'b0;
        transferBiasOff = 1'b1;
        cyc(1);
        transferBiasOff = 1'b0;
        chk(periodCode, PEPSEQ_CODE_LAST_ROT);
        drumMotorStopped = 1'b1;
        cmd({1'b0, again, 1'b0});
        drumMotorStopped = 1'b0;
        chk(periodCode, again ? PEPSEQ_CODE_INIT_ROT
                              : PEPSEQ_CODE_IDLE);
    endtask : do_page
    task automatic t_wait();
        chk({beltCleanReq, checkReq, adjustReq, periodCode}, 8'h38);
        checksDone = 1'b1;
        adjustNeeded = 1'b1;
        cmd(3'h6);
        checksDone = 1'b0;
        chk({checkReq, adjustReq, periodCode}, 8'h08);
        adjustDone = 1'b1;
        cyc(3);
        {adjustDone, adjustNeeded} = 2'h0;
        chk({adjustReq, periodCode}, {1'b0, PEPSEQ_CODE_WAIT});
        beltCleanDone = 1'b1;
        cyc(1);
        beltCleanDone = 1'b0;
        chk({readyToPrint, periodCode}, {1'b1, PEPSEQ_CODE_IDLE});
    endtask : t_wait
    task automatic t_sleep();
        cyc(3);
        chk(periodCode, PEPSEQ_CODE_IDLE);
        cmd(3'h4);
        chk({lowPowerMode, periodCode}, {1'b1, PEPSEQ_CODE_SLEEP});
        cmd(3'h2);
        chk({lowPowerMode, periodCode}, {1'b0, PEPSEQ_CODE_IDLE});
        cmd(3'h4);
        cmd(3'h1);
        chk(periodCode, PEPSEQ_CODE_IDLE);
    endtask : t_sleep
    task automatic t_status();
        {tonerLow, cartridgeMissing, subsysFault} = 3'h5;
        cyc(1);
        {tonerLow, cartridgeMissing, subsysFault} = 3'h2;
        chk({statusTonerLow, statusNoCartridge, statusFault}, 8'h5);
        cyc(1);
        {tonerLow, cartridgeMissing, subsysFault} = 3'h0;
        chk({statusTonerLow, statusNoCartridge, statusFault}, 8'h2);
    endtask : t_status
    // Every tenth page is restarted from last rotation
    task automatic t_clean();
        for (int p = 1; p <= 100; p++) begin
            {cartCleanDone, beltCleanDone} = 2'h0;
            do_page(p % 10 == 3);
            // Divider tick, then pending flag: two edges after page end
            cyc(1);
            if (p % 10 != 3) begin
                chk(cartCleanReq, p == 35 || p == 70);
                chk(beltCleanReq, p == 100);
            end
            cartCleanDone = (p == 35 || p == 70);
            beltCleanDone = (p == 100);
            cyc(1);
        end
        {cartCleanDone, beltCleanDone} = 2'h0;
        chk({cartCleanReq, beltCleanReq}, 8'h0);
    endtask : t_clean

    initial begin
        {rst_b, printCmd, sleepCmd, wakeCmd} = 4'h0;
        {beltCleanDone, cartCleanDone, checksDone, adjustNeeded} = 4'h0;
        {adjustDone, rotationReady, leadingEdgeSensed} = 3'h0;
        {transferBiasOff, drumMotorStopped, tonerLow} = 3'h0;
        {cartridgeMissing, subsysFault} = 2'h0;
        cyc(4);
        rst_b = 1'b1;
        t_wait();
        t_sleep();
        t_status();
        t_clean();
        print_verdict();
    end
    // Run needs about 920 cycles; over sixteen times that means a hang
    initial begin
        #150000;
        failures++;
        print_verdict();
    end
endmodule : tb

`default_nettype wire
